// >>> inc/t8w_pkg.sv
// shared constants and types of the 8-bit dual compare timer
package t8w_pkg;

  // ----------------------------------------------------------------
  // register map: printed offsets are indices, byte address is 4x
  // ----------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam logic [7:0] IDX_CTRL_A = 8'hb0;
  localparam logic [7:0] IDX_CTRL_B = 8'hb1;
  localparam logic [7:0] IDX_COUNT = 8'hb2;
  localparam logic [7:0] IDX_FLAGS = 8'h37;
  localparam logic [7:0] IDX_AUX = 8'hb5;
  localparam logic [9:0] ADDR_CTRL_A = {IDX_CTRL_A, 2'h0};
  localparam logic [9:0] ADDR_CTRL_B = {IDX_CTRL_B, 2'h0};
  localparam logic [9:0] ADDR_COUNT = {IDX_COUNT, 2'h0};
  localparam logic [9:0] ADDR_FLAGS = {IDX_FLAGS, 2'h0};
  localparam logic [9:0] ADDR_AUX = {IDX_AUX, 2'h0};

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CA_COM_A_LSB = 6;
  localparam int CA_COM_B_LSB = 4;
  localparam int CA_WGM_LSB = 0;
  localparam logic [7:0] CA_WR_MASK = 8'hf3;
  localparam int CB_FORCE_A = 7;
  localparam int CB_FORCE_B = 6;
  localparam int CB_WGM_HI = 3;
  localparam int CB_CS_LSB = 0;
  localparam logic [7:0] CB_WR_MASK = 8'h0f;
  localparam int FL_OVF = 0;
  localparam int FL_MATCH_A = 1;
  localparam int FL_MATCH_B = 2;
  localparam int AUX_PSR = 0;
  localparam logic [7:0] RST_CTRL_A = 8'h00;
  localparam logic [7:0] RST_CTRL_B = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] MAX_VAL = 8'hff;
  localparam logic [7:0] BOTTOM_VAL = 8'h00;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] WM_NORMAL = 3'h0;
  localparam logic [2:0] WM_PHASE_FF = 3'h1;
  localparam logic [2:0] WM_CTC = 3'h2;
  localparam logic [2:0] WM_FAST_FF = 3'h3;
  localparam logic [2:0] WM_RSVD_4 = 3'h4;
  localparam logic [2:0] WM_PHASE_CA = 3'h5;
  localparam logic [2:0] WM_RSVD_6 = 3'h6;
  localparam logic [2:0] WM_FAST_CA = 3'h7;
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOG = 2'h1;
  localparam logic [1:0] COM_CLR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV32 = 3'h3;
  localparam logic [2:0] CS_DIV64 = 3'h4;
  localparam logic [2:0] CS_DIV128 = 3'h5;
  localparam logic [2:0] CS_DIV256 = 3'h6;
  localparam logic [2:0] CS_DIV1024 = 3'h7;

  // ----------------------------------------------------------------
  // prescaler ratios
  // ----------------------------------------------------------------
  localparam int PRE_W = 10;
  localparam int DIV_8 = 8;
  localparam int DIV_32 = 32;
  localparam int DIV_64 = 64;
  localparam int DIV_128 = 128;
  localparam int DIV_256 = 256;
  localparam int DIV_1024 = 1024;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {K_NONPWM, K_FAST, K_PHASE, K_RSVD} t8w_kind_e;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [9:0] addr;
    logic [7:0] wdata;
  } t8w_bus_req_s;

  typedef struct packed {
    logic [9:0] cnt;
    logic tick;
  } t8w_pre_s;

  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] cnt;
    logic dir_down;
    logic [7:0] ocr_a;
    logic [7:0] ocr_b;
    logic block;
    logic out_a;
    logic out_b;
    logic con_a;
    logic con_b;
    logic [2:0] flags;
    logic [7:0] rdata;
  } t8w_state_s;

endpackage

// >>> verilog/t8w_prescaler.sv
// prescaler producing the counter tick from the timer source clock
module t8w_prescaler (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic restart_i,
  input wire logic [2:0] clock_select_i,
  output logic tick_o
);

  // ----------------------------------------------------------------
  // ratio decode
  // ----------------------------------------------------------------
  function automatic logic [9:0] mask_of(input logic [2:0] sel);
    case (sel)
      t8w_pkg::CS_DIV8: mask_of = 10'(t8w_pkg::DIV_8 - 1);
      t8w_pkg::CS_DIV32: mask_of = 10'(t8w_pkg::DIV_32 - 1);
      t8w_pkg::CS_DIV64: mask_of = 10'(t8w_pkg::DIV_64 - 1);
      t8w_pkg::CS_DIV128: mask_of = 10'(t8w_pkg::DIV_128 - 1);
      t8w_pkg::CS_DIV256: mask_of = 10'(t8w_pkg::DIV_256 - 1);
      t8w_pkg::CS_DIV1024: mask_of = 10'(t8w_pkg::DIV_1024 - 1);
      default: mask_of = 10'h000;
    endcase
  endfunction

  t8w_pkg::t8w_pre_s s_q;
  t8w_pkg::t8w_pre_s s_d;
  logic [9:0] m;

  // ----------------------------------------------------------------
  // free running divider, shared by every ratio
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    m = mask_of(clock_select_i);
    s_d.cnt = restart_i ? 10'h000 : 10'(s_q.cnt + 10'h001);
    case (clock_select_i)
      t8w_pkg::CS_STOP: s_d.tick = 1'b0;
      t8w_pkg::CS_DIV1: s_d.tick = 1'b1;
      default: s_d.tick = ((s_q.cnt & m) == m) && !restart_i;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_o = s_q.tick;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_div8_quiet;
    (clock_select_i == t8w_pkg::CS_DIV8 && !restart_i)[*7];
  endsequence

  chk_div8_period: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (clock_select_i == t8w_pkg::CS_DIV8 && !restart_i) ##1
      (tick_o && clock_select_i == t8w_pkg::CS_DIV8 && !restart_i) ##1 s_div8_quiet
      |=> tick_o)
    else $error("divide by 8 tick period wrong");

  chk_restart_phase: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (restart_i && clock_select_i != t8w_pkg::CS_DIV1) |=> !tick_o)
    else $error("tick right after prescaler restart");

endmodule // t8w_prescaler

// >>> verilog/t8w_timer.sv
// 8-bit timer with two compare channels and waveform generation
//
// Behaviour
// - nonzero output mode B connects output B, except toggle in PWM modes and all reserved modes
// - non-PWM B modes: off, toggle, clear, set
// - fast PWM B: clear/set match, opposite BOTTOM
// - phase PWM B: direction decides clear or set
// - compare B at TOP ignored, act at TOP
// - waveform mode selects sequence and TOP
// - compare buffers load immediate or at TOP
// - overflow flag at MAX, TOP or BOTTOM
// - force bits work only outside PWM modes
// - force bit strobes immediate compare match
// - forced match sets no flag, no clear
// - force bits always read as zero
// - clock select stops or divides the counter
// - counter register read and write, reset zero
// - counter write blocks next tick's match
// - control B field layout, reset zero
// - non-PWM A modes: off, toggle, clear, set
// - match flag B set, cleared by ack/one
// - io clock source, prescaler restart bit
//
// Chosen here: the plain strobed port.
module t8w_timer (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire t8w_pkg::t8w_bus_req_s bus_req_i,
  input wire logic [7:0] cmp_a_i,
  input wire logic [7:0] cmp_b_i,
  input wire logic [2:0] flag_ack_i,
  output logic [7:0] rd_data_o,
  output logic compare_out_a_o,
  output logic compare_out_b_o,
  output logic out_a_connect_o,
  output logic out_b_connect_o,
  output logic [2:0] flags_o
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic t8w_pkg::t8w_kind_e kind_of(input logic [2:0] wm);
    case (wm)
      t8w_pkg::WM_NORMAL, t8w_pkg::WM_CTC: kind_of = t8w_pkg::K_NONPWM;
      t8w_pkg::WM_FAST_FF, t8w_pkg::WM_FAST_CA: kind_of = t8w_pkg::K_FAST;
      t8w_pkg::WM_PHASE_FF, t8w_pkg::WM_PHASE_CA: kind_of = t8w_pkg::K_PHASE;
      default: kind_of = t8w_pkg::K_RSVD;
    endcase
  endfunction

  // output connected to the pin; reserved combinations stay off
  function automatic logic connected(input t8w_pkg::t8w_kind_e k, input logic [1:0] com,
                                     input logic tog_ok);
    connected = (com != t8w_pkg::COM_OFF) && (k != t8w_pkg::K_RSVD) &&
                !(k != t8w_pkg::K_NONPWM && com == t8w_pkg::COM_TOG && !tog_ok);
  endfunction

  // next level of a compare output
  function automatic logic wave_next(input t8w_pkg::t8w_kind_e k, input logic [1:0] com,
                                     input logic cur, input logic match, input logic special,
                                     input logic wrap, input logic top_evt, input logic down,
                                     input logic tog_ok);
    logic m;
    m = match && !special;
    wave_next = cur;
    case (k)
      t8w_pkg::K_NONPWM: begin
        if (match) begin
          case (com)
            t8w_pkg::COM_TOG: wave_next = !cur;
            t8w_pkg::COM_CLR: wave_next = 1'b0;
            t8w_pkg::COM_SET: wave_next = 1'b1;
            default: wave_next = cur;
          endcase
        end
      end
      t8w_pkg::K_FAST: begin
        // with compare at TOP only the level at the wrap remains
        if (com == t8w_pkg::COM_TOG && tog_ok && match) begin
          wave_next = !cur;
        end else if (com[1] && wrap) begin
          wave_next = !com[0];
        end else if (com[1] && m) begin
          wave_next = com[0];
        end
      end
      t8w_pkg::K_PHASE: begin
        if (com == t8w_pkg::COM_TOG && tog_ok && match) begin
          wave_next = !cur;
        end else if (com[1] && special && top_evt) begin
          wave_next = com[0];
        end else if (com[1] && m) begin
          wave_next = down ? !com[0] : com[0];
        end
      end
      default: wave_next = cur;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // state and decode
  // ----------------------------------------------------------------
  t8w_pkg::t8w_state_s s_q;
  t8w_pkg::t8w_state_s s_d;
  logic tick;
  logic psr_restart;
  logic [2:0] wm;
  t8w_pkg::t8w_kind_e kind;
  logic [7:0] top;
  logic [7:0] oa;
  logic [7:0] ob;
  logic at_top;
  logic at_bot;
  logic match_a;
  logic match_b;
  logic force_a;
  logic force_b;
  logic ovf;
  logic wrap;
  logic top_evt;
  logic tog_ok;
  logic wr_ca;
  logic wr_cb;
  logic wr_cnt;
  logic wr_fl;
  logic wr_aux;
  logic [2:0] fl_clr;

  assign wr_ca = bus_req_i.wr && bus_req_i.addr == t8w_pkg::ADDR_CTRL_A;
  assign wr_cb = bus_req_i.wr && bus_req_i.addr == t8w_pkg::ADDR_CTRL_B;
  assign wr_cnt = bus_req_i.wr && bus_req_i.addr == t8w_pkg::ADDR_COUNT;
  assign wr_fl = bus_req_i.wr && bus_req_i.addr == t8w_pkg::ADDR_FLAGS;
  assign wr_aux = bus_req_i.wr && bus_req_i.addr == t8w_pkg::ADDR_AUX;
  assign psr_restart = wr_aux && bus_req_i.wdata[t8w_pkg::AUX_PSR];

  assign wm = {s_q.ctrl_b[t8w_pkg::CB_WGM_HI], s_q.ctrl_a[t8w_pkg::CA_WGM_LSB +: 2]};
  assign kind = kind_of(wm);
  assign tog_ok = s_q.ctrl_b[t8w_pkg::CB_WGM_HI];
  // outside PWM the live compare values act at once
  assign oa = (kind == t8w_pkg::K_NONPWM) ? cmp_a_i : s_q.ocr_a;
  assign ob = (kind == t8w_pkg::K_NONPWM) ? cmp_b_i : s_q.ocr_b;
  assign top = (wm == t8w_pkg::WM_CTC || wm == t8w_pkg::WM_PHASE_CA ||
                wm == t8w_pkg::WM_FAST_CA) ? oa : t8w_pkg::MAX_VAL;
  assign at_top = s_q.cnt == top;
  assign at_bot = s_q.cnt == t8w_pkg::BOTTOM_VAL;
  assign match_a = tick && !s_q.block && kind != t8w_pkg::K_RSVD && s_q.cnt == oa;
  assign match_b = tick && !s_q.block && kind != t8w_pkg::K_RSVD && s_q.cnt == ob;
  assign force_a = wr_cb && bus_req_i.wdata[t8w_pkg::CB_FORCE_A] &&
                   kind == t8w_pkg::K_NONPWM;
  assign force_b = wr_cb && bus_req_i.wdata[t8w_pkg::CB_FORCE_B] &&
                   kind == t8w_pkg::K_NONPWM;
  assign wrap = tick && kind == t8w_pkg::K_FAST && at_top;
  assign top_evt = tick && kind == t8w_pkg::K_PHASE && !s_q.dir_down && at_top;

  always_comb begin
    case (wm)
      t8w_pkg::WM_NORMAL, t8w_pkg::WM_CTC, t8w_pkg::WM_FAST_FF:
        ovf = tick && s_q.cnt == t8w_pkg::MAX_VAL;
      t8w_pkg::WM_FAST_CA: ovf = tick && at_top;
      t8w_pkg::WM_PHASE_FF, t8w_pkg::WM_PHASE_CA:
        ovf = tick && s_q.dir_down && at_bot;
      default: ovf = 1'b0;
    endcase
  end

  t8w_prescaler u_prescaler (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .restart_i(psr_restart),
    .clock_select_i(s_q.ctrl_b[t8w_pkg::CB_CS_LSB +: 3]),
    .tick_o(tick)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.rdata = 8'h00;
    fl_clr = flag_ack_i | (wr_fl ? bus_req_i.wdata[2:0] : 3'h0);

    // direction only means something in phase correct mode; a down flag left
    // over from it would keep the fast mode buffers from ever loading
    if (kind != t8w_pkg::K_PHASE) begin
      s_d.dir_down = 1'b0;
    end

    // counting sequence
    if (tick) begin
      s_d.block = 1'b0;
      case (kind)
        t8w_pkg::K_NONPWM: begin
          // a forced match never reaches this clear
          if (wm == t8w_pkg::WM_CTC && at_top) begin
            s_d.cnt = t8w_pkg::BOTTOM_VAL;
          end else begin
            s_d.cnt = 8'(s_q.cnt + 8'h01);
          end
        end
        t8w_pkg::K_FAST: begin
          s_d.cnt = at_top ? t8w_pkg::BOTTOM_VAL : 8'(s_q.cnt + 8'h01);
        end
        t8w_pkg::K_PHASE: begin
          if (!s_q.dir_down) begin
            s_d.dir_down = at_top;
            s_d.cnt = at_top ? 8'(s_q.cnt - 8'h01) : 8'(s_q.cnt + 8'h01);
          end else begin
            s_d.dir_down = !at_bot;
            s_d.cnt = at_bot ? 8'(s_q.cnt + 8'h01) : 8'(s_q.cnt - 8'h01);
          end
        end
        default: s_d.cnt = s_q.cnt;
      endcase
    end

    // compare buffers: PWM values load once per period, on the tick at
    // TOP while counting up, so a period never sees two different thresholds
    if (kind != t8w_pkg::K_PHASE && kind != t8w_pkg::K_FAST) begin
      s_d.ocr_a = cmp_a_i;
      s_d.ocr_b = cmp_b_i;
    end else if (tick && at_top && !s_q.dir_down) begin
      s_d.ocr_a = cmp_a_i;
      s_d.ocr_b = cmp_b_i;
    end

    // waveform outputs
    s_d.out_a = wave_next(kind, s_q.ctrl_a[t8w_pkg::CA_COM_A_LSB +: 2], s_q.out_a,
                          match_a || force_a, s_q.ctrl_a[t8w_pkg::CA_COM_A_LSB + 1] &&
                          oa == top, wrap, top_evt, s_q.dir_down, tog_ok);
    s_d.out_b = wave_next(kind, s_q.ctrl_a[t8w_pkg::CA_COM_B_LSB +: 2], s_q.out_b,
                          match_b || force_b, s_q.ctrl_a[t8w_pkg::CA_COM_B_LSB + 1] &&
                          ob == top, wrap, top_evt, s_q.dir_down, 1'b0);
    s_d.con_a = connected(kind, s_q.ctrl_a[t8w_pkg::CA_COM_A_LSB +: 2], tog_ok);
    s_d.con_b = connected(kind, s_q.ctrl_a[t8w_pkg::CA_COM_B_LSB +: 2], 1'b0);

    // flags: a set in the same cycle as a clear wins; forces never set
    s_d.flags = (s_q.flags & ~fl_clr) | {match_b, match_a, ovf};

    // register writes
    if (wr_ca) begin
      s_d.ctrl_a = bus_req_i.wdata & t8w_pkg::CA_WR_MASK;
    end
    if (wr_cb) begin
      s_d.ctrl_b = bus_req_i.wdata & t8w_pkg::CB_WR_MASK;
    end
    if (wr_cnt) begin
      s_d.cnt = bus_req_i.wdata;
      s_d.block = 1'b1;
    end

    // register reads, answered in the next cycle only
    if (bus_req_i.rd) begin
      case (bus_req_i.addr)
        t8w_pkg::ADDR_CTRL_A: s_d.rdata = s_q.ctrl_a;
        t8w_pkg::ADDR_CTRL_B: s_d.rdata = s_q.ctrl_b;
        t8w_pkg::ADDR_COUNT: s_d.rdata = s_q.cnt;
        t8w_pkg::ADDR_FLAGS: s_d.rdata = {5'h00, s_q.flags};
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data_o = s_q.rdata;
  assign compare_out_a_o = s_q.out_a;
  assign compare_out_b_o = s_q.out_b;
  assign out_a_connect_o = s_q.con_a;
  assign out_b_connect_o = s_q.con_b;
  assign flags_o = s_q.flags;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb_sys @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_cnt_write;
    bus_req_i.wr && bus_req_i.addr == t8w_pkg::ADDR_COUNT;
  endsequence

  sequence s_rd_ctrl_b;
    bus_req_i.rd && bus_req_i.addr == t8w_pkg::ADDR_CTRL_B;
  endsequence

  chk_force_read_zero: assert property (s_rd_ctrl_b |=> rd_data_o[7:6] == 2'h0)
    else $error("force bits read back nonzero");

  chk_count_readback: assert property (
    s_cnt_write ##1 (bus_req_i.rd && bus_req_i.addr == t8w_pkg::ADDR_COUNT && !tick &&
                     !bus_req_i.wr)
      |=> rd_data_o == $past(bus_req_i.wdata, 2))
    else $error("counter write not read back");

  // the blocked tick may come long after the write when the counter is slow
  chk_write_blocks: assert property (
    (s_q.block && tick && s_q.cnt == ob && flag_ack_i == 3'h0 &&
     !flags_o[t8w_pkg::FL_MATCH_B])
      |=> !flags_o[t8w_pkg::FL_MATCH_B])
    else $error("match taken on tick after counter write");

  chk_stopped_hold: assert property (
    (s_q.ctrl_b[2:0] == t8w_pkg::CS_STOP && !tick && !bus_req_i.wr) |=> $stable(s_q.cnt))
    else $error("stopped counter moved");

  chk_ctc_clear: assert property (
    (tick && wm == t8w_pkg::WM_CTC && s_q.cnt == cmp_a_i && !bus_req_i.wr)
      |=> s_q.cnt == t8w_pkg::BOTTOM_VAL)
    else $error("clear on match did not clear");

  chk_normal_ovf: assert property (
    (tick && wm == t8w_pkg::WM_NORMAL && s_q.cnt == t8w_pkg::MAX_VAL)
      |=> flags_o[t8w_pkg::FL_OVF])
    else $error("overflow flag missed at MAX");

  chk_force_toggle: assert property (
    (force_b && !tick && s_q.ctrl_a[5:4] == t8w_pkg::COM_TOG) |=>
      compare_out_b_o != $past(compare_out_b_o))
    else $error("forced toggle of output B missing");

  chk_force_no_flag: assert property (
    (force_a && !tick && s_q.flags == 3'h0) |=> flags_o == 3'h0)
    else $error("forced match raised a flag");

  chk_fast_wrap_set: assert property (
    (wrap && s_q.ctrl_a[5:4] == t8w_pkg::COM_CLR) |=> compare_out_b_o)
    else $error("non-inverting output not set at BOTTOM");

  chk_flag_set_wins: assert property (
    (match_b && wr_fl && bus_req_i.wdata[t8w_pkg::FL_MATCH_B]) |=>
      flags_o[t8w_pkg::FL_MATCH_B])
    else $error("clear beat a simultaneous match");

  chk_phase_turn: assert property (
    (top_evt && !bus_req_i.wr) |=> s_q.dir_down ##1 1'b1)
    else $error("phase correct count did not turn at TOP");

endmodule // t8w_timer

// >>> test/t8w_timer_tb.sv
// self-checking bench of the 8-bit dual compare timer
module t8w_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i;
  logic rst_i;
  t8w_pkg::t8w_bus_req_s bus_req_i;
  logic [7:0] cmp_a_i;
  logic [7:0] cmp_b_i;
  logic [2:0] flag_ack_i;
  logic [7:0] rd_data_o;
  logic compare_out_a_o;
  logic compare_out_b_o;
  logic out_a_connect_o;
  logic out_b_connect_o;
  logic [2:0] flags_o;
  logic [8:0] exp_q[$];
  logic [8:0] note;
  logic rd_seen;
  logic [31:0] lfsr;
  logic [7:0] v0;
  logic [7:0] v1;
  int n_errors;
  int n_tests;
  int h;
  int divs[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  logic [1:0] fm[4] = '{2'h3, 2'h2, 2'h1, 2'h1};
  logic [3:0] fo = 4'h5;

  `define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin n_errors++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  t8w_timer i_dut (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .bus_req_i(bus_req_i),
    .cmp_a_i(cmp_a_i),
    .cmp_b_i(cmp_b_i),
    .flag_ack_i(flag_ack_i),
    .rd_data_o(rd_data_o),
    .compare_out_a_o(compare_out_a_o),
    .compare_out_b_o(compare_out_b_o),
    .out_a_connect_o(out_a_connect_o),
    .out_b_connect_o(out_b_connect_o),
    .flags_o(flags_o)
  );

  // ----------------------------------------------------------------
  // bus driver and read monitor
  // ----------------------------------------------------------------
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic bus(input logic r, input logic [9:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    bus_req_i <= '{rd: r, wr: !r, addr: a, wdata: d};
    @(posedge sys_clk_i);
    bus_req_i <= '0;
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    bus(1'b0, a, d);
  endtask

  // write then read with no idle cycle between the strobes
  task automatic wr_rd(input logic [9:0] a, input logic [7:0] d, input logic [7:0] e);
    exp_q.push_back({1'b1, e});
    @(posedge sys_clk_i);
    bus_req_i <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    bus(1'b1, a, 8'h00);
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    exp_q.push_back({1'b1, e});
    bus(1'b1, a, 8'h00);
  endtask

  // unchecked read: the value feeds a later comparison
  task automatic rd_get(input logic [9:0] a, output logic [7:0] v);
    exp_q.push_back(9'h000);
    bus(1'b1, a, 8'h00);
    #1 v = rd_data_o;
  endtask

  task automatic settle();
    @(posedge sys_clk_i);
    #1;
  endtask

  task automatic wait_flag(input int b, input int lim);
    int k;
    k = 0;
    while (flags_o[b] !== 1'b1 && k < lim) begin
      @(posedge sys_clk_i);
      k++;
    end
    if (k >= lim) begin
      n_errors++;
      $display("wrong value flags_o expected set seen clear");
      results();
    end
  endtask

  // duty of output b over one full period, sampled before each edge lands
  task automatic duty(input logic [7:0] ca, input logic [7:0] cb, input logic [7:0] a,
                      input logic [7:0] b, input int per);
    wr(t8w_pkg::ADDR_CTRL_B, 8'h00);
    wr(t8w_pkg::ADDR_CTRL_A, ca);
    cmp_a_i <= a;
    cmp_b_i <= b;
    wr(t8w_pkg::ADDR_CTRL_B, cb);
    repeat (600) @(posedge sys_clk_i);
    h = 0;
    repeat (per) begin
      @(posedge sys_clk_i);
      if (compare_out_b_o === 1'b1) h++;
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge sys_clk_i) begin
    if (rd_seen && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      if (note[8]) `CHK("rd_data_o", note[7:0], rd_data_o)
    end
    rd_seen <= bus_req_i.rd;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    bus_req_i = '0;
    cmp_a_i = 8'h00;
    cmp_b_i = 8'h00;
    flag_ack_i = 3'h0;
    rd_seen = 1'b0;
    lfsr = 32'h16fcd;
    repeat (6) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd(t8w_pkg::ADDR_CTRL_A, 8'h00);
    rd(t8w_pkg::ADDR_CTRL_B, 8'h00);
    rd(t8w_pkg::ADDR_COUNT, 8'h00);
    rd(10'h004, 8'h00);
    wr(t8w_pkg::ADDR_CTRL_B, 8'hf8);
    rd(t8w_pkg::ADDR_CTRL_B, 8'h08);
    wr(t8w_pkg::ADDR_CTRL_B, 8'h00);
    for (int i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      wr_rd(t8w_pkg::ADDR_COUNT, lfsr[7:0], lfsr[7:0]);
    end
    $display("test registers done");
    // force strobes with the counter stopped, so only the strobe moves outputs
    for (int i = 0; i < 4; i++) begin
      cmp_a_i <= lfsr[15:8];
      wr(t8w_pkg::ADDR_CTRL_A, {fm[i], fm[i], 4'h0});
      wr(t8w_pkg::ADDR_CTRL_B, 8'hc0);
      settle();
      `CHK("compare_out_b_o", fo[i], compare_out_b_o)
      `CHK("compare_out_a_o", fo[i], compare_out_a_o)
      `CHK("out_b_connect_o", 1'b1, out_b_connect_o)
      `CHK("flags_o", 3'h0, flags_o)
    end
    wr(t8w_pkg::ADDR_CTRL_A, 8'h00);
    settle();
    `CHK("out_b_connect_o", 1'b0, out_b_connect_o)
    wr(t8w_pkg::ADDR_CTRL_A, 8'h12);
    wr(t8w_pkg::ADDR_COUNT, 8'h33);
    wr(t8w_pkg::ADDR_CTRL_B, 8'h40);
    rd(t8w_pkg::ADDR_COUNT, 8'h33);
    wr(t8w_pkg::ADDR_CTRL_A, 8'h23);
    wr(t8w_pkg::ADDR_CTRL_B, 8'h40);
    settle();
    `CHK("compare_out_b_o", 1'b1, compare_out_b_o)
    $display("test force done");
    wr(t8w_pkg::ADDR_CTRL_A, 8'h00);
    cmp_b_i <= 8'hf8;
    wr(t8w_pkg::ADDR_COUNT, 8'hf0);
    wr(t8w_pkg::ADDR_CTRL_B, 8'h01);
    wait_flag(2, 40);
    `CHK("overflow early", 1'b0, flags_o[0])
    wait_flag(0, 40);
    flag_ack_i <= 3'h1;
    @(posedge sys_clk_i);
    flag_ack_i <= 3'h0;
    settle();
    `CHK("overflow ack", 1'b0, flags_o[0])
    wr(t8w_pkg::ADDR_FLAGS, 8'h04);
    settle();
    `CHK("match b clear", 1'b0, flags_o[2])
    // a written counter equal to the compare value must not match on its first tick
    wr(t8w_pkg::ADDR_CTRL_B, 8'h00);
    cmp_b_i <= 8'h07;
    wr(t8w_pkg::ADDR_FLAGS, 8'h07);
    wr(t8w_pkg::ADDR_COUNT, 8'h07);
    wr(t8w_pkg::ADDR_CTRL_B, 8'h01);
    repeat (12) settle();
    `CHK("match b blocked", 1'b0, flags_o[2])
    $display("test flags done");
    for (int c = 0; c < 8; c++) begin
      wr(t8w_pkg::ADDR_CTRL_B, {5'h00, 3'(c)});
      wr(t8w_pkg::ADDR_AUX, 8'h01);
      repeat (4) @(posedge sys_clk_i);
      rd_get(t8w_pkg::ADDR_COUNT, v0);
      repeat ((c == 0) ? 14 : 2 * divs[c] - 2) @(posedge sys_clk_i);
      rd_get(t8w_pkg::ADDR_COUNT, v1);
      `CHK("ticks", (c == 0) ? 8'h00 : 8'h02, 8'(v1 - v0))
    end
    $display("test prescaler done");
    duty(8'h23, 8'h01, 8'h00, 8'h80, 256);
    `CHK("fast duty", 129, h)
    duty(8'h33, 8'h01, 8'h00, 8'h80, 256);
    `CHK("fast inverted duty", 127, h)
    duty(8'h23, 8'h01, 8'h00, 8'hff, 256);
    `CHK("fast duty at top", 256, h)
    duty(8'h21, 8'h01, 8'h00, 8'h80, 510);
    `CHK("phase duty", 256, h)
    duty(8'h31, 8'h01, 8'h00, 8'h80, 510);
    `CHK("phase inverted duty", 254, h)
    duty(8'h12, 8'h01, 8'h0f, 8'h05, 32);
    `CHK("ctc toggle", 16, h)
    duty(8'h23, 8'h09, 8'h3f, 8'h10, 64);
    `CHK("top from compare a", 17, h)
    wr(t8w_pkg::ADDR_FLAGS, 8'h07);
    wait_flag(0, 70);
    wr(t8w_pkg::ADDR_CTRL_A, 8'h30);
    rd_get(t8w_pkg::ADDR_COUNT, v0);
    repeat (10) @(posedge sys_clk_i);
    rd_get(t8w_pkg::ADDR_COUNT, v1);
    `CHK("reserved hold", v0, v1)
    `CHK("out_b_connect_o", 1'b0, out_b_connect_o)
    $display("test waveforms done");
    results();
  end
endmodule // t8w_timer_tb
